// ### inc/rcg_pkg.sv
// register map, field positions, reset values and bus carriers for the rc48 clock-control slice
// assumes a 32-bit APB bus with byte strobes and a 12-bit byte address
package rcg_pkg;

  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          STRB_W         = 4;

  localparam logic [11:0] OFF_OSC_CTL    = 12'h0C0;
  localparam logic [11:0] OFF_OSC_INT    = 12'h0CC;
  localparam logic [11:0] OFF_APB1_RST   = 12'h0E0;
  localparam logic [11:0] OFF_APB1_EN    = 12'h0E4;

  localparam int          CTL_TRIM_LSB   = 24;
  localparam int          CTL_TRIM_W     = 8;
  localparam int          CTL_STB_BIT    = 17;
  localparam int          CTL_EN_BIT     = 16;
  localparam int          CTL_SEL_BIT    = 0;
  localparam int          INT_CLR_BIT    = 22;
  localparam int          INT_IE_BIT     = 14;
  localparam int          INT_IF_BIT     = 6;
  localparam int          RST_TRIM_BIT   = 27;
  localparam int          EN_TRIM_BIT    = 27;

  localparam logic [31:0] CTL_RESET      = 32'h8000_0000;
  localparam logic [7:0]  TRIM_RESET     = 8'h80;
  localparam logic [31:0] INT_RESET      = 32'h0000_0000;
  localparam logic [31:0] APB1_RST_RESET = 32'h0000_0000;
  localparam logic [31:0] APB1_EN_RESET  = 32'h0000_0000;

  typedef struct packed {
    logic              sel;
    logic              enable;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [STRB_W-1:0] strb;
  } rcg_apb_req_t;

  typedef struct packed {
    logic              ready;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } rcg_apb_rsp_t;

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

endpackage : rcg_pkg

// ### core/rcg_apb_if.sv
// APB slave handshake: one wait state, registered ready, read data and error
// assumes the master holds the request stable until ready is seen high
`timescale 1ns/100ps
module rcg_apb_if (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire rcg_pkg::rcg_apb_req_t req,
  input  wire logic [31:0]          rdata_mux,
  input  wire logic                 addr_hit,
  output rcg_pkg::rcg_apb_rsp_t     rsp_q,
  output logic                      wr_commit
);

  // first access cycle: latch the answer; ready rises on the following edge
  wire access_first = req.sel & req.enable & ~rsp_q.ready;

  // write lands only at the edge where ready is sampled high
  assign wr_commit = req.sel & req.enable & rsp_q.ready & req.write & addr_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ready  <= access_first;
      rsp_q.slverr <= access_first & ~addr_hit;
      rsp_q.rdata  <= (access_first & ~req.write & addr_hit) ? rdata_mux : 32'h0000_0000;
    end
  end

endmodule : rcg_apb_if

// ### core/rcg_irq.sv
// sticky event flag with software clear and registered interrupt level
// assumes set and clear are single-cycle pulses from the same clock
`timescale 1ns/100ps
module rcg_irq (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_evt,
  input  wire logic clr_evt,
  output logic      flag_q,
  output logic      irq_q
);

  // a set in the clearing cycle wins, so no event is lost
  wire flag_d = set_evt | (flag_q & ~clr_evt);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      flag_q <= flag_d;
      irq_q  <= flag_d;
    end
  end

endmodule : rcg_irq

// ### core/rcg_top.sv
// clock-control register slice for the internal 48 MHz rc oscillator and the clock trim unit
// assumes APB on pclk, the oscillator and power-mode inputs synchronous to pclk
//
// Behaviour
// RQ1: factory trim byte loaded at power-on, read-only
// RQ2: bit 17 shows oscillator stable, else zero
// RQ3: enable software rw, cleared entering low power
// RQ4: select 0 uses pll clock, 1 rc oscillator
// RQ5: writing 1 to clear bit drops flag
// RQ6: flag set when oscillator stabilises while enabled
// RQ7: enable bit gates the stabilisation interrupt
// RQ8: trim unit held in reset while bit set
// RQ9: trim unit clock gated by enable, reset off
// RQ10: byte, half-word and word accesses accepted
// RQ11: software writes reserved bits with reset values
// RQ12: interrupt output follows the stabilisation flag
`timescale 1ns/100ps
module rcg_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic [7:0]  osc_factory_trim_value,
  input  wire logic        internal_rc_48mhz_osc_ready,
  input  wire logic        low_power_entry,
  output logic             osc_enable,
  output logic [7:0]       osc_trim_out,
  output logic             clk48_source_select,
  output logic             trim_unit_reset,
  output logic             trim_unit_clock_enable,
  output logic             clk_irq
);

  // bus carriers
  rcg_pkg::rcg_apb_req_t req;
  rcg_pkg::rcg_apb_rsp_t rsp_q;
  logic                  wr_commit;

  // register state
  logic [7:0]            trim_q;
  logic                  trim_loaded_q;
  logic                  stable_q;
  logic                  stable_prev_q;
  logic                  osc_en_q;
  logic                  src_sel_q;
  logic                  irq_en_q;
  logic                  trim_rst_q;
  logic                  trim_clk_en_q;
  logic                  irq_flag;
  logic                  irq_level;

  assign req.sel    = psel;
  assign req.enable = penable;
  assign req.write  = pwrite;
  assign req.addr   = paddr;
  assign req.wdata  = pwdata;
  assign req.strb   = pstrb;

  // address decode; low two bits ignored because every register is a whole word
  wire [11:0] word_addr = {paddr[11:2], 2'b00};
  wire        hit_ctl   = (word_addr == rcg_pkg::OFF_OSC_CTL);
  wire        hit_int   = (word_addr == rcg_pkg::OFF_OSC_INT);
  wire        hit_rst   = (word_addr == rcg_pkg::OFF_APB1_RST);
  wire        hit_en    = (word_addr == rcg_pkg::OFF_APB1_EN);
  wire        addr_hit  = hit_ctl | hit_int | hit_rst | hit_en;

  wire        wr_ctl    = wr_commit & hit_ctl;
  wire        wr_int    = wr_commit & hit_int;
  wire        wr_rst    = wr_commit & hit_rst;
  wire        wr_en     = wr_commit & hit_en;

  // read images; reserved bits read as zero
  wire [31:0] ctl_img = {trim_q, 6'h00, stable_q, osc_en_q, 15'h0000, src_sel_q};  // [RQ1] [RQ2]
  wire [31:0] int_img = {9'h000, 1'b0, 7'h00, irq_en_q, 7'h00, irq_flag, 6'h00};    // [RQ5]
  wire [31:0] rst_img = {4'h0, trim_rst_q, 27'h0000000};
  wire [31:0] en_img  = {4'h0, trim_clk_en_q, 27'h0000000};

  wire [31:0] rdata_mux = hit_ctl ? ctl_img :
                          hit_int ? int_img :
                          hit_rst ? rst_img :
                          hit_en  ? en_img  : 32'h0000_0000;

  // strobed write images; partial accesses touch only their lanes
  wire [31:0] ctl_wr = rcg_pkg::merge_bytes(ctl_img, pwdata, pstrb);  // [RQ10]
  wire [31:0] int_wr = rcg_pkg::merge_bytes(32'h0000_0000 | int_img, pwdata, pstrb);
  wire [31:0] rst_wr = rcg_pkg::merge_bytes(rst_img, pwdata, pstrb);  // [RQ10]
  wire [31:0] en_wr  = rcg_pkg::merge_bytes(en_img, pwdata, pstrb);

  // the clear bit acts only when its own lane is written
  wire        clr_hit = wr_int & pstrb[rcg_pkg::INT_CLR_BIT/8]
                        & pwdata[rcg_pkg::INT_CLR_BIT];  // [RQ5]

  // stabilisation event: rising edge of the ready input, gated by the enable
  wire        stable_rise = stable_q & ~stable_prev_q;
  wire        stb_event   = stable_rise & irq_en_q;  // [RQ6] [RQ7]

  rcg_apb_if u_apb (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (req),
    .rdata_mux (rdata_mux),
    .addr_hit  (addr_hit),
    .rsp_q     (rsp_q),
    .wr_commit (wr_commit)
  );

  rcg_irq u_irq (
    .pclk    (pclk),
    .presetn (presetn),
    .set_evt (stb_event),
    .clr_evt (clr_hit),
    .flag_q  (irq_flag),
    .irq_q   (irq_level)
  );

  assign pready  = rsp_q.ready;
  assign prdata  = rsp_q.rdata;
  assign pslverr = rsp_q.slverr;
  assign clk_irq = irq_level;  // [RQ12]

  // factory trim: reset value until the first edge after release, then fixed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q        <= rcg_pkg::TRIM_RESET;
      trim_loaded_q <= 1'b0;
    end else if (!trim_loaded_q) begin
      trim_q        <= osc_factory_trim_value;  // [RQ1]
      trim_loaded_q <= 1'b1;
    end
  end

  // stability status follows the oscillator input, one flop late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable_q      <= 1'b0;
      stable_prev_q <= 1'b0;
    end else begin
      stable_q      <= internal_rc_48mhz_osc_ready;  // [RQ2]
      stable_prev_q <= stable_q;
    end
  end

  // low-power entry beats a software write in the same cycle, so the
  // oscillator can never stay enabled across a deep-sleep request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_en_q  <= rcg_pkg::CTL_RESET[rcg_pkg::CTL_EN_BIT];
      src_sel_q <= rcg_pkg::CTL_RESET[rcg_pkg::CTL_SEL_BIT];
    end else begin
      if (low_power_entry) begin
        osc_en_q <= 1'b0;  // [RQ3]
      end else if (wr_ctl) begin
        osc_en_q <= ctl_wr[rcg_pkg::CTL_EN_BIT];  // [RQ3]
      end
      if (wr_ctl) begin
        src_sel_q <= ctl_wr[rcg_pkg::CTL_SEL_BIT];  // [RQ4]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_q <= rcg_pkg::INT_RESET[rcg_pkg::INT_IE_BIT];
    end else if (wr_int) begin
      irq_en_q <= int_wr[rcg_pkg::INT_IE_BIT];  // [RQ7]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_rst_q    <= rcg_pkg::APB1_RST_RESET[rcg_pkg::RST_TRIM_BIT];
      trim_clk_en_q <= rcg_pkg::APB1_EN_RESET[rcg_pkg::EN_TRIM_BIT];
    end else begin
      if (wr_rst) begin
        trim_rst_q <= rst_wr[rcg_pkg::RST_TRIM_BIT];  // [RQ8]
      end
      if (wr_en) begin
        trim_clk_en_q <= en_wr[rcg_pkg::EN_TRIM_BIT];  // [RQ9]
      end
    end
  end

  // outputs to the clock tree; the 48 MHz mux itself sits in the clock tree,
  // which keeps clock muxing out of this synchronous slice
  assign osc_enable             = osc_en_q;
  assign osc_trim_out           = trim_q;
  assign clk48_source_select    = src_sel_q;   // [RQ4]
  assign trim_unit_reset        = trim_rst_q;  // [RQ8]
  assign trim_unit_clock_enable = trim_clk_en_q;  // [RQ9]

  // software is trusted to write reserved bits as zero; the image simply
  // drops them, so a wrong write cannot disturb state [RQ11]

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_trim_fixed: assert property (trim_loaded_q |=> $stable(trim_q)) // [RQ1]
    else $error("factory trim changed after load");

  a_trim_loaded: assert property ($rose(trim_loaded_q) |-> trim_q == $past(osc_factory_trim_value)) // [RQ1]
    else $error("factory trim not captured");

  a_stable_track: assert property (stable_q == $past(internal_rc_48mhz_osc_ready)) // [RQ2]
    else $error("stability flag not following oscillator");

  a_lowpower_clears: assert property (low_power_entry |=> !osc_enable) // [RQ3]
    else $error("enable survived low-power entry");

  a_enable_write: assert property (wr_ctl && !low_power_entry && pstrb[2]
                                   |=> osc_enable == $past(pwdata[16])) // [RQ3]
    else $error("enable write lost");

  a_select_write: assert property (wr_ctl && pstrb[0]
                                   |=> clk48_source_select == $past(pwdata[0])) // [RQ4]
    else $error("source select write lost");

  a_flag_clear: assert property (clr_hit && !stb_event |=> !irq_flag ##1 !clk_irq) // [RQ5]
    else $error("flag not cleared");

  a_flag_cause: assert property ($rose(irq_flag) |-> $past(stable_rise) && $past(irq_en_q)) // [RQ6]
    else $error("flag set without enabled stabilisation");

  a_flag_masked: assert property (stable_rise && !irq_en_q && !irq_flag |=> !irq_flag) // [RQ7]
    else $error("masked event set flag");

  a_trim_reset: assert property (wr_rst && pstrb[3]
                                 |=> trim_unit_reset == $past(pwdata[27])) // [RQ8]
    else $error("trim reset write lost");

  a_trim_clock: assert property (wr_en && pstrb[3]
                                 |=> trim_unit_clock_enable == $past(pwdata[27])) // [RQ9]
    else $error("trim clock enable write lost");

  a_byte_keep: assert property (wr_ctl && !pstrb[2] && !low_power_entry
                                |=> $stable(osc_enable)) // [RQ10]
    else $error("unstrobed lane modified");

  a_irq_level: assert property (clk_irq == irq_flag) // [RQ12]
    else $error("interrupt output differs from flag");

  a_apb_answer: assert property (psel && penable && !pready |=> pready ##1 !pready) // [RQ10]
    else $error("apb answer not one wait state");

  c_stab_irq: cover property (stb_event ##[1:20] clr_hit);
  c_lowpower: cover property (osc_enable ##1 low_power_entry ##1 !osc_enable);
  c_byte_write: cover property (wr_commit && pstrb == 4'h1);
  c_set_clear: cover property (stb_event && clr_hit);

endmodule : rcg_top

// ### sim/rcg_top_tb.sv
// self-checking bench for the rc48 clock-control slice: apb traffic checked against an int model
// assumes rcg_pkg is compiled first; the bench drives every port of rcg_top itself
`timescale 1ns/100ps
module rcg_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  trim_in, trim_out;
  logic        rdy, lpe, en_o, sel_o, rst_o, cen_o, irq, er;
  int          n_fail, checks, k;
  int          m_en, m_sel, m_ie, m_flag, m_rst, m_cen, m_trim, m_stb;
  logic [11:0] offs [4] = '{rcg_pkg::OFF_OSC_CTL, rcg_pkg::OFF_OSC_INT,
                            rcg_pkg::OFF_APB1_RST, rcg_pkg::OFF_APB1_EN};
  // only writable bits are randomised, reserved bits stay at their reset value
  logic [31:0] wm [4] = '{32'h0001_0001, 32'h0000_4000, 32'h0800_0000, 32'h0800_0000};

  rcg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .osc_factory_trim_value(trim_in),
    .internal_rc_48mhz_osc_ready(rdy), .low_power_entry(lpe), .osc_enable(en_o),
    .osc_trim_out(trim_out), .clk48_source_select(sel_o), .trim_unit_reset(rst_o),
    .trim_unit_clock_enable(cen_o), .clk_irq(irq));

  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp,
                         input logic ge, input logic ee);
    checks++;
    if (got !== exp || ge !== ee) begin
      n_fail++;
      $display("BAD %0t read %h err %b, want %h err %b", $time, got, ge, exp, ee);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp, input string nm);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t pin %s is %h, want %h", $time, nm, got, exp);
    end
  endtask : chk_pin

  // request held from setup until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 16) begin
      n_fail++;
      $display("BAD %0t no ready", $time);
    end
  endtask : apb

  function automatic logic [31:0] expv(input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      rcg_pkg::OFF_OSC_CTL:  v = (m_trim << 24) | (m_stb << 17) | (m_en << 16) | m_sel;
      rcg_pkg::OFF_OSC_INT:  v = (m_ie << 14) | (m_flag << 6);
      rcg_pkg::OFF_APB1_RST: v = m_rst << 27;
      rcg_pkg::OFF_APB1_EN:  v = m_cen << 27;
      default:               v = 32'h0;
    endcase
    return v;
  endfunction : expv

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    apb(1'h1, a, d, s);
    if (a == rcg_pkg::OFF_OSC_CTL && m[16]) m_en = d[16];
    if (a == rcg_pkg::OFF_OSC_CTL && m[0]) m_sel = d[0];
    if (a == rcg_pkg::OFF_OSC_INT && m[14]) m_ie = d[14];
    if (a == rcg_pkg::OFF_OSC_INT && m[22] && d[22]) m_flag = 0;
    if (a == rcg_pkg::OFF_APB1_RST && m[27]) m_rst = d[27];
    if (a == rcg_pkg::OFF_APB1_EN && m[27]) m_cen = d[27];
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic ee);
    apb(1'h0, a, 32'h0, 4'h0);
    chk_reg(rd, expv(a), er, ee);
  endtask : rdc

  task automatic pins;
    chk_pin({7'h0, en_o}, 8'(m_en), "enable");
    chk_pin({7'h0, sel_o}, 8'(m_sel), "select");
    chk_pin({7'h0, rst_o}, 8'(m_rst), "trim reset");
    chk_pin({7'h0, cen_o}, 8'(m_cen), "trim clock");
    chk_pin({7'h0, irq}, 8'(m_flag), "irq");
    chk_pin(trim_out, 8'(m_trim), "trim");
  endtask : pins

  // the design sees the ready level one edge late and sets the flag one edge after that, so settle before reading
  task automatic set_rdy(input logic v);
    @(posedge pclk);
    rdy <= v;
    repeat (4) @(posedge pclk);
    if (v && m_stb == 0 && m_ie == 1) m_flag = 1;
    m_stb = v;
  endtask : set_rdy

  initial begin
    #(3000 * 100);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    void'($urandom(80));
    {psel, penable, pwrite, paddr, pwdata, pstrb, rdy, lpe, presetn} = '0;
    {m_en, m_sel, m_ie, m_flag, m_rst, m_cen, m_stb} = '0;
    trim_in = 8'($urandom);
    m_trim = trim_in;
    repeat (8) @(posedge pclk);
    chk_pin(trim_out, rcg_pkg::TRIM_RESET, "trim in reset");
    presetn <= 1'h1;
    repeat (2) @(posedge pclk);
    pins();
    for (k = 0; k < 4; k++) rdc(offs[k], 1'h0);
    for (k = 0; k < 40; k++) begin
      wr(offs[k % 4], $urandom & wm[k % 4], 4'($urandom));
      rdc(offs[k % 4], 1'h0);
      pins();
    end
    apb(1'h1, 12'h0D0, 32'hFFFF_FFFF, 4'hF);
    chk_reg(rd, 32'h0, er, 1'h1);
    rdc(12'h0C4, 1'h1);
    for (k = 0; k < 4; k++) rdc(offs[k], 1'h0);
    wr(rcg_pkg::OFF_OSC_INT, 32'h0000_4000, 4'h2);
    set_rdy(1'h1);
    rdc(rcg_pkg::OFF_OSC_CTL, 1'h0);
    rdc(rcg_pkg::OFF_OSC_INT, 1'h0);
    pins();
    wr(rcg_pkg::OFF_OSC_INT, 32'h0000_4000, 4'hF);
    rdc(rcg_pkg::OFF_OSC_INT, 1'h0);
    wr(rcg_pkg::OFF_OSC_INT, 32'h0040_4000, 4'h4);
    rdc(rcg_pkg::OFF_OSC_INT, 1'h0);
    pins();
    set_rdy(1'h0);
    rdc(rcg_pkg::OFF_OSC_CTL, 1'h0);
    wr(rcg_pkg::OFF_OSC_INT, 32'h0, 4'h2);
    set_rdy(1'h1);
    rdc(rcg_pkg::OFF_OSC_INT, 1'h0);
    pins();
    wr(rcg_pkg::OFF_OSC_CTL, 32'h0001_0001, 4'h5);
    pins();
    @(posedge pclk);
    lpe <= 1'h1;
    @(posedge pclk);
    lpe <= 1'h0;
    m_en = 0;
    @(posedge pclk);
    pins();
    rdc(rcg_pkg::OFF_OSC_CTL, 1'h0);
    tally_and_finish();
  end
endmodule : rcg_top_tb
